// ===== inc/region_cfg_params.svh
/*
  Offsets, field positions, reset values and sizing for the region
  configuration block. Included by the package and the design files.
*/
`ifndef REGION_CFG_PARAMS_SVH
`define REGION_CFG_PARAMS_SVH

`define OFF_SLOT_SELECT 12'h000
`define OFF_REGION_BASE 12'h004
`define OFF_REGION_ATTR 12'h008
`define OFF_PROT_CTRL 12'h00C
`define OFF_REGION_FLAGS 12'h010

`define NUM_REGIONS 8
`define SLOT_W 8
`define ADDR_LSB 5
`define MIN_ALIGN_BITS 5
`define BASE_DIRECT_BIT 4
`define BASE_SLOT_HI 3
`define ATTR_NOEXEC_BIT 28
`define ATTR_AP_HI 26
`define ATTR_AP_LO 24
`define ATTR_TEX_HI 21
`define ATTR_TEX_LO 19
`define ATTR_S_BIT 18
`define ATTR_C_BIT 17
`define ATTR_B_BIT 16
`define SRD_HI 15
`define SRD_LO 8
`define SIZE_HI 5
`define SIZE_LO 1
`define SIZE_MIN_CODE 5'h04
`define SIZE_SUBREGION_CODE 5'h07
`define ATTR_WRITABLE_MASK 32'h173FFF3F
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h00000000
`define ATTR_RESET 32'h00000000
`define BASE_RESET 27'h0000000

`endif

// ===== inc/region_cfg_pkg.sv
/*
  Types shared by the region configuration block.
  Assumes the params header sits beside it on the include path.
*/
`include "region_cfg_params.svh"

package region_cfg_pkg;
  typedef logic [`SLOT_W-1:0] slot_t;
  typedef logic [31-`ADDR_LSB:0] base_t;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_DONE = 2'b01
  } apb_phase_e;
endpackage : region_cfg_pkg

// ===== rtl/region_decode.sv
/*
  Combinational view of one region's attribute word: field split, size in
  bytes as log2, and the effective enable under the global enable.
  Assumes the attribute word is already masked of reserved bits.
*/
`timescale 1ns/10ps
`include "region_cfg_params.svh"

module region_decode
  import region_cfg_pkg::*;
(
  input wire logic [31:0] attr_word,
  input wire logic prot_enable,
  output logic active,
  output logic no_execute,
  output logic [2:0] access_permission,
  output logic [2:0] type_extension,
  output logic [2:0] scb,
  output logic [7:0] subregion_disable_mask,
  output logic [5:0] size_log2,
  output logic subregions_valid
);
  logic [4:0] size_code;

  assign size_code = attr_word[`SIZE_HI:`SIZE_LO];
  // region of 2^(code+1) bytes; 6 bits cover up to 4GB
  assign size_log2 = {1'b0, size_code} + 6'h01;
  // region counts only under the global enable
  assign active = attr_word[0] & prot_enable;
  assign no_execute = attr_word[`ATTR_NOEXEC_BIT];
  assign access_permission = attr_word[`ATTR_AP_HI:`ATTR_AP_LO];
  assign type_extension = attr_word[`ATTR_TEX_HI:`ATTR_TEX_LO];
  assign scb = attr_word[`ATTR_S_BIT:`ATTR_B_BIT];
  // bit 0 of the mask is the lowest-addressed eighth
  assign subregion_disable_mask = attr_word[`SRD_HI:`SRD_LO];
  assign subregions_valid = (size_code >= `SIZE_SUBREGION_CODE);
endmodule : region_decode

// ===== rtl/region_cfg.sv
/*
  Region protection configuration registers behind an APB slave:
  slot select, region base, region attribute/size and protection control,
  plus a read-only view of each region's effective enable.
  Assumes an APB master on mclk; answers every transfer with no wait state.
*/
`timescale 1ns/10ps
`include "region_cfg_params.svh"

module region_cfg
  import region_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic prot_enable,
  output logic use_default_map,
  output logic [`NUM_REGIONS-1:0] region_active,
  output logic sel_no_execute,
  output logic [2:0] sel_access_permission,
  output logic [7:0] sel_subregion_disable_mask,
  output logic [5:0] sel_size_log2
);
  localparam int RIDX_W = $clog2(`NUM_REGIONS);

  slot_t slot_q;
  base_t base_q [`NUM_REGIONS];
  logic [31:0] attr_q [`NUM_REGIONS];
  logic [31:0] ctrl_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic slverr_d;
  logic slverr_q;
  logic wr_en;
  logic rd_en;
  logic sel_in_range;
  logic [RIDX_W-1:0] sel_idx;
  logic [31:0] sel_attr;
  logic [`NUM_REGIONS-1:0] flags;
  slot_t wr_slot;
  logic [RIDX_W-1:0] wr_idx;
  logic [31:0] base_merged;
  base_t sel_base;
  logic base_wr_full;
  logic attr_wr_full;

  // writes other than protection control honour byte strobes so partial writes keep untouched lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic slot_ok(input slot_t s);
    return s < slot_t'(`NUM_REGIONS);
  endfunction : slot_ok

  // writes in access phase, reads in setup; every transfer completes in its first access cycle
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = psel & penable & slverr_q;

  assign sel_in_range = slot_ok(slot_q);
  assign sel_idx = slot_q[RIDX_W-1:0];
  assign sel_attr = sel_in_range ? attr_q[sel_idx] : 32'h00000000;
  assign sel_base = sel_in_range ? base_q[sel_idx] : `BASE_RESET;

  // direct form takes the slot from the written word, else slot select
  assign wr_slot = pwdata[`BASE_DIRECT_BIT] ? {4'h0, pwdata[`BASE_SLOT_HI:0]} : slot_q;
  assign wr_idx = wr_slot[RIDX_W-1:0];

  // strobed lanes merged over the stored word; the low five bits drop at the store
  // a call result cannot be sliced, so the merge gets a net of its own
  assign base_merged = merge({base_q[wr_idx], 5'h00}, pwdata, pstrb);

  // whole-word writes, used by the checks below
  // partial strobes are exercised from the bench
  assign base_wr_full = wr_en && paddr == `OFF_REGION_BASE && pstrb == 4'hF;
  assign attr_wr_full = wr_en && paddr == `OFF_REGION_ATTR && sel_in_range && pstrb == 4'hF;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_en && paddr == `OFF_PROT_CTRL) begin
      ctrl_q <= {31'h00000000, pwdata[`CTRL_ENABLE_BIT]};
    end
  end

  assign prot_enable = ctrl_q[`CTRL_ENABLE_BIT];
  assign use_default_map = ~prot_enable;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slot_q <= '0;
    end else if (wr_en && paddr == `OFF_SLOT_SELECT && pstrb[0]) begin
      slot_q <= pwdata[`SLOT_W-1:0];
    end else if (wr_en && paddr == `OFF_REGION_BASE && pwdata[`BASE_DIRECT_BIT]
                 && pstrb[0]) begin
      slot_q <= {4'h0, pwdata[`BASE_SLOT_HI:0]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `NUM_REGIONS; i++) begin
        base_q[i] <= `BASE_RESET;
      end
    end else if (wr_en && paddr == `OFF_REGION_BASE && slot_ok(wr_slot)) begin
      // bits below the minimum alignment are not stored
      base_q[wr_idx] <= base_merged[31:`ADDR_LSB];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `NUM_REGIONS; i++) begin
        attr_q[i] <= `ATTR_RESET;
      end
    end else if (wr_en && paddr == `OFF_REGION_ATTR && sel_in_range) begin
      // reserved bits dropped on write
      attr_q[sel_idx] <= merge(attr_q[sel_idx], pwdata, pstrb) & `ATTR_WRITABLE_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_REGIONS; g++) begin : g_region
      region_decode u_dec (
        .attr_word(attr_q[g]),
        .prot_enable(prot_enable),
        .active(flags[g]),
        .no_execute(),
        .access_permission(),
        .type_extension(),
        .scb(),
        .subregion_disable_mask(),
        .size_log2(),
        .subregions_valid()
      );
    end
  endgenerate

  assign region_active = flags;

  region_decode u_sel (
    .attr_word(sel_attr),
    .prot_enable(prot_enable),
    .active(),
    .no_execute(sel_no_execute),
    .access_permission(sel_access_permission),
    .type_extension(),
    .scb(),
    .subregion_disable_mask(sel_subregion_disable_mask),
    .size_log2(sel_size_log2),
    .subregions_valid()
  );

  // read data captured in setup so it stands from flops in access phase
  always_comb begin
    rdata_d = 32'h00000000;
    slverr_d = 1'b0;
    unique case (paddr)
      `OFF_SLOT_SELECT: rdata_d = {24'h000000, slot_q};
      // direct bit always zero, low nibble mirrors slot select
      `OFF_REGION_BASE: rdata_d = {sel_base, 1'b0, slot_q[`BASE_SLOT_HI:0]};
      `OFF_REGION_ATTR: rdata_d = sel_attr;
      `OFF_PROT_CTRL: rdata_d = ctrl_q;
      `OFF_REGION_FLAGS: rdata_d = {{(32-`NUM_REGIONS){1'b0}}, flags};
      default: slverr_d = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  // error flag follows decode in setup for both directions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      slverr_q <= slverr_d;
    end
  end

  a_direct_slot: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_REGION_BASE && pwdata[4] && pstrb[0]
    |=> slot_q == {4'h0, $past(pwdata[3:0])})
    else $error("direct base write did not update slot select");

  a_indirect_keep: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_REGION_BASE && !pwdata[4] |=> $stable(slot_q))
    else $error("indirect base write changed slot select");

  a_base_lowbits: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_BASE |=> prdata[4:0] == {1'b0, $past(slot_q[3:0])})
    else $error("base read low bits wrong");

  a_attr_reserved: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_ATTR |=> (prdata & ~`ATTR_WRITABLE_MASK) == 32'h0)
    else $error("reserved attribute bits not zero");

  a_gate_enable: assert property (@(posedge mclk) disable iff (rst)
    !prot_enable |-> region_active == '0)
    else $error("region active without global enable");

  a_default_map: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_PROT_CTRL |=> use_default_map == !$past(pwdata[0]))
    else $error("default map flag wrong");

  a_slot_write: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_SLOT_SELECT && pstrb[0] |=> slot_q == $past(pwdata[7:0]))
    else $error("slot select not written");

  a_attr_write: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_REGION_ATTR && sel_in_range && pstrb == 4'hF
    |=> attr_q[$past(sel_idx)] == ($past(pwdata) & `ATTR_WRITABLE_MASK))
    else $error("attribute write lost");

  a_base_align: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_BASE ##1 psel && penable
    |-> prdata[31:5] == $past(sel_base))
    else $error("base read mismatch");

  // full-word writes give a value that can be checked whole
  a_base_indirect: assert property (@(posedge mclk) disable iff (rst)
    base_wr_full && !pwdata[4] && sel_in_range
    |=> base_q[$past(sel_idx)] == $past(pwdata[31:5]))
    else $error("indirect base write missed the selected region");

  a_base_direct: assert property (@(posedge mclk) disable iff (rst)
    base_wr_full && pwdata[4] && !pwdata[3]
    |=> base_q[$past(pwdata[2:0])] == $past(pwdata[31:5]))
    else $error("direct base write missed the named region");

  a_base_unbacked: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_BASE && !sel_in_range
    |=> prdata[31:5] == `BASE_RESET)
    else $error("base read of unbacked slot not zero");

  a_direct_zero: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_BASE |=> !prdata[4])
    else $error("direct bit read back as one");

  a_attr_fields: assert property (@(posedge mclk) disable iff (rst)
    attr_wr_full
    |=> sel_no_execute == $past(pwdata[28])
        && sel_access_permission == $past(pwdata[26:24]))
    else $error("attribute fields not decoded");

  a_attr_mask: assert property (@(posedge mclk) disable iff (rst)
    attr_wr_full |=> sel_subregion_disable_mask == $past(pwdata[15:8]))
    else $error("subregion mask not decoded");

  a_mask_lowest: assert property (@(posedge mclk) disable iff (rst)
    attr_wr_full && pwdata[8] |=> sel_subregion_disable_mask[0])
    else $error("lowest subregion bit misplaced");

  a_size_field: assert property (@(posedge mclk) disable iff (rst)
    attr_wr_full |=> sel_size_log2 == {1'b0, $past(pwdata[5:1])} + 6'h01)
    else $error("region size not decoded");

  a_size_max: assert property (@(posedge mclk) disable iff (rst)
    attr_wr_full && pwdata[5:1] == 5'h1F |=> sel_size_log2 == 6'h20)
    else $error("largest region size not reached");

  // read-back checks see the word captured at setup
  a_attr_unbacked: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_ATTR && !sel_in_range |=> prdata == 32'h00000000)
    else $error("attribute read of unbacked slot not zero");

  a_region_enable: assert property (@(posedge mclk) disable iff (rst)
    prot_enable && sel_in_range |-> region_active[sel_idx] == sel_attr[0])
    else $error("region enable not passed through");

  a_flags_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_REGION_FLAGS |=> prdata == {24'h000000, $past(region_active)})
    else $error("active flags read wrong");

  a_ctrl_write: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_PROT_CTRL |=> prot_enable == $past(pwdata[0]))
    else $error("global enable not written");

  a_ctrl_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_PROT_CTRL |=> prdata == {31'h0, $past(prot_enable)})
    else $error("control read wrong");

  a_slot_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && paddr == `OFF_SLOT_SELECT |=> prdata == {24'h000000, $past(slot_q)})
    else $error("slot select read wrong");

  // a write without lane 0 must leave the slot alone
  a_slot_strobe: assert property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == `OFF_SLOT_SELECT && !pstrb[0] |=> $stable(slot_q))
    else $error("slot select written without its lane");

  // main scenarios
  c_direct_write: cover property (@(posedge mclk) wr_en && paddr == `OFF_REGION_BASE
    && pwdata[4]);
  c_indirect_write: cover property (@(posedge mclk) base_wr_full && !pwdata[4]);
  c_attr_enable: cover property (@(posedge mclk) prot_enable && region_active != '0);
  c_subregions: cover property (@(posedge mclk) sel_subregion_disable_mask != 8'h00
    && sel_size_log2 >= 6'h08);
  c_bad_addr: cover property (@(posedge mclk) pslverr);
endmodule : region_cfg

// ===== tb/region_cfg_tb.sv
/*
  Self-checking bench for the region configuration block, driven over APB.
  Assumes the params header on the include path and zero-wait-state slave.
*/
`timescale 1ns/10ps
`include "region_cfg_params.svh"

module region_cfg_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic prot_enable, use_default_map, sel_no_execute;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [7:0] region_active, sel_subregion_disable_mask;
  logic [2:0] sel_access_permission;
  logic [5:0] sel_size_log2;
  int fails, comparisons;

  region_cfg i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prot_enable(prot_enable), .use_default_map(use_default_map),
    .region_active(region_active), .sel_no_execute(sel_no_execute),
    .sel_access_permission(sel_access_permission),
    .sel_subregion_disable_mask(sel_subregion_disable_mask),
    .sel_size_log2(sel_size_log2));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task end_of_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // request held from setup until pready is seen high at an access edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(exp, rdata);
  endtask : rd

  // outputs are combinational from registers; look mid-cycle
  task settle;
    @(negedge mclk);
  endtask : settle

  task t_reset;
    chk(32'h00000001, {31'h0, use_default_map});
    chk(32'h00000000, {24'h0, region_active});
    rd(`OFF_REGION_BASE, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  task t_base;
    wr(`OFF_SLOT_SELECT, 32'h00000003);
    wr(`OFF_REGION_BASE, 32'hFFFFFFEF);
    rd(`OFF_SLOT_SELECT, 32'h00000003);
    rd(`OFF_REGION_BASE, 32'hFFFFFFE3);
    wr(`OFF_REGION_BASE, 32'h00001015);
    rd(`OFF_SLOT_SELECT, 32'h00000005);
    rd(`OFF_REGION_BASE, 32'h00001005);
    wr(`OFF_SLOT_SELECT, 32'h00000003);
    rd(`OFF_REGION_BASE, 32'hFFFFFFE3);
    pstrb <= 4'h1;
    wr(`OFF_REGION_BASE, 32'h0000FF00);
    pstrb <= 4'hF;
    rd(`OFF_REGION_BASE, 32'hFFFFFF03);
    $display("test base done");
  endtask : t_base

  task t_attr;
    wr(`OFF_SLOT_SELECT, 32'h00000002);
    wr(`OFF_REGION_ATTR, 32'hFFFFFFFF);
    rd(`OFF_REGION_ATTR, 32'h173FFF3F);
    settle();
    chk(32'h00000001, {31'h0, sel_no_execute});
    chk(32'h00000007, {29'h0, sel_access_permission});
    chk(32'h000000FF, {24'h0, sel_subregion_disable_mask});
    chk(32'h00000020, {26'h0, sel_size_log2});
    wr(`OFF_REGION_ATTR, 32'h03040109);
    rd(`OFF_REGION_ATTR, 32'h03040109);
    settle();
    chk(32'h00000005, {26'h0, sel_size_log2});
    chk(32'h00000001, {24'h0, sel_subregion_disable_mask});
    chk(32'h00000003, {29'h0, sel_access_permission});
    chk(32'h00000000, {31'h0, sel_no_execute});
    wr(`OFF_REGION_BASE, 32'h00000040);
    rd(`OFF_REGION_BASE, 32'h00000042);
    wr(`OFF_SLOT_SELECT, 32'h00000003);
    settle();
    chk(32'h00000001, {26'h0, sel_size_log2});
    $display("test attr done");
  endtask : t_attr

  task t_enable;
    chk(32'h00000000, {24'h0, region_active});
    wr(`OFF_PROT_CTRL, 32'h00000001);
    settle();
    chk(32'h00000004, {24'h0, region_active});
    chk(32'h00000000, {31'h0, use_default_map});
    chk(32'h00000001, {31'h0, prot_enable});
    wr(`OFF_PROT_CTRL, 32'h00000000);
    settle();
    chk(32'h00000001, {31'h0, use_default_map});
    chk(32'h00000000, {24'h0, region_active});
    $display("test enable done");
  endtask : t_enable

  // unmapped word: error answer, read data zero
  task t_unmapped;
    apb(1'b0, 12'h020, 32'h00000000);
    chk(32'h00000001, {31'h0, rerr});
    chk(32'h00000000, rdata);
    $display("test unmapped done");
  endtask : t_unmapped

  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_base();
    t_attr();
    t_enable();
    t_unmapped();
    end_of_test();
  end
endmodule : region_cfg_tb
